// File: prs_consts.svh
// Register offsets, field positions and reset values of the reference switch control
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Register offsets
`define PRS_ADDR_REF_CTRL 10'h01C
`define PRS_ADDR_HOLD_CTRL 10'h01D
`define PRS_ADDR_PLL_STATUS 10'h01F

// Reset values
`define PRS_REF_CTRL_RST 8'h00
`define PRS_HOLD_CTRL_RST 8'h00
`define PRS_UNMAPPED_RDATA 8'h00

// Reference switch control fields
`define PRS_RC_NO_DEGLITCH 7
`define PRS_RC_SEL_SECONDARY 6
`define PRS_RC_USE_PIN 5
`define PRS_RC_AUTO 4
`define PRS_RC_STAY_SECONDARY 3
`define PRS_RC_SEC_POWER 2
`define PRS_RC_PRI_POWER 1
`define PRS_RC_DIFFERENTIAL 0

// Holdover control fields
`define PRS_HC_STATUS_OFF 4
`define PRS_HC_LOCK_CMP_EN 3
`define PRS_HC_HOLD_EN_B 2
`define PRS_HC_EXTERNAL 1
`define PRS_HC_HOLD_EN_A 0

// Status fields
`define PRS_ST_CAL_DONE 6
`define PRS_ST_HOLDOVER 5
`define PRS_ST_SECONDARY 4
`define PRS_ST_VCO_ABOVE 3
`define PRS_ST_SEC_ABOVE 2
`define PRS_ST_PRI_ABOVE 1
`define PRS_ST_DIG_LOCK 0

`endif

// File: prs_pkg.sv
// Types of the reference switch and holdover control block
`default_nettype none
package prs_pkg;

   // Reference change sequencing
   typedef enum logic [1:0] {
      PRS_SW_RUN,
      PRS_SW_DRAIN_OLD,
      PRS_SW_WAIT_NEW
   } prs_sw_state_t;

   // Automatic holdover controller
   typedef enum logic {
      PRS_HO_TRACK,
      PRS_HO_HOLD
   } prs_ho_state_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] ref_ctrl;
      logic [7:0] hold_ctrl;
      logic [11:0] sync1;
      logic [11:0] sync2;
      logic sel;
      logic tgt;
      logic ref_out;
      logic holdover;
      prs_sw_state_t sw;
      prs_ho_state_t ho;
      logic [7:0] rdata;
   } prs_state_t;

endpackage
`default_nettype wire

// File: prs_ref_src.sv
// Behavioural reference clock source in front of the block
`default_nettype none
module prs_ref_src #(
   parameter int HALF_NS = 350
) (
   input wire logic i_en,
   output logic o_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   // Toggles only while its input buffer is powered, else rests low
   initial begin
      o_clk = 1'h0;
      forever begin
         #(HALF_NS);
         o_clk = i_en ? !o_clk : 1'h0;
      end
   end
endmodule
`default_nettype wire

// File: prs_ref_switch_ctrl.sv
// Reference selection, switchover, holdover control and status registers of the PLL front end
//
// Function
// - Control bit 7 set disables switchover deglitching.
// - Manual register mode: bit 6 picks reference.
// - Manual mode: bit 5 picks register or pin.
// - Bit 4 selects automatic switchover, single-ended only.
// - Bit 3 clear returns to primary when good.
// - Manual mode: bits 2,1 power secondary, primary.
// - Bit 0 selects differential, forcing primary path.
// - Holdover bit 4 blanks the status readback.
// - Comparator off means lock input treated high.
// - Comparator on: lock pin says previously locked.
// - Holdover needs both bit 2 and bit 0.
// - Bit 1 hands holdover to sync pin.
// - Status bit 6 shows calibration finished.
// - Status bit 5 shows holdover state active.
// - Status bit 4 shows secondary driving PLL.
// - Status bit 3 shows VCO above threshold.
// - Status bit 0 shows digital lock detect.
// - Status bit 2 shows secondary above threshold.
`include "prs_consts.svh"
`default_nettype none

module prs_ref_switch_ctrl #(
   parameter int ADDR_W = 10
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Reference clocks and pins
   input wire logic i_primary_reference,
   input wire logic i_secondary_reference,
   input wire logic i_ref_select_pin,
   input wire logic i_lock_indicator_pin,
   input wire logic i_sync_n,
   // Monitor and PLL status levels
   input wire logic i_pri_status_good,
   input wire logic i_sec_status_good,
   input wire logic i_pri_above_thr,
   input wire logic i_sec_above_thr,
   input wire logic i_vco_above_thr,
   input wire logic i_vco_cal_done,
   input wire logic i_dig_lock,
   // Outputs to the PLL front end
   output logic o_ref_to_pll,
   output logic o_secondary_selected,
   output logic o_holdover,
   output logic o_pri_power,
   output logic o_sec_power,
   output logic o_differential
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser bit positions

   localparam int S_PRI_CLK = 0;
   localparam int S_SEC_CLK = 1;
   localparam int S_SEL_PIN = 2;
   localparam int S_LOCK_PIN = 3;
   localparam int S_SYNC_N = 4;
   localparam int S_PRI_GOOD = 5;
   localparam int S_SEC_GOOD = 6;
   localparam int S_PRI_ABOVE = 7;
   localparam int S_SEC_ABOVE = 8;
   localparam int S_VCO_ABOVE = 9;
   localparam int S_CAL_DONE = 10;
   localparam int S_DIG_LOCK = 11;

   ////////////////////////////////////////////////////////////////////////////
   // State

   prs_pkg::prs_state_t r_q;
   prs_pkg::prs_state_t r_d;
   logic [11:0] pins;

   // Gather the asynchronous inputs into one vector
   assign pins = {i_dig_lock, i_vco_cal_done, i_vco_above_thr, i_sec_above_thr,
                  i_pri_above_thr, i_sec_status_good, i_pri_status_good, i_sync_n,
                  i_lock_indicator_pin, i_ref_select_pin, i_secondary_reference,
                  i_primary_reference};

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Address match against a register offset
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   // Reference the PLL should be fed from; 1 means secondary
   function automatic logic pick_target(input logic [7:0] rc, input logic cur,
                                        input logic pin, input logic pri_good);
      logic t;
      t = cur;
      if (rc[`PRS_RC_DIFFERENTIAL]) begin
         t = 1'b0;
      end else if (rc[`PRS_RC_AUTO]) begin
         if (!cur) begin
            t = !pri_good;
         end else begin
            t = !(pri_good && !rc[`PRS_RC_STAY_SECONDARY]);
         end
      end else if (rc[`PRS_RC_USE_PIN]) begin
         t = pin;
      end else begin
         t = rc[`PRS_RC_SEL_SECONDARY];
      end
      pick_target = t;
   endfunction

   // Level of one of the two reference clocks after synchronising
   function automatic logic ref_level(input logic [11:0] s, input logic which);
      ref_level = which ? s[S_SEC_CLK] : s[S_PRI_CLK];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic want;
   logic hold_en;
   logic lock_ok;
   logic sel_good;
   logic [7:0] status;

   always_comb begin
      r_d = r_q;
      want = 1'b0;
      hold_en = 1'b0;
      lock_ok = 1'b0;
      sel_good = 1'b0;
      status = 8'h00;

      // Two flip-flops on every outside level
      r_d.sync1 = pins;
      r_d.sync2 = r_q.sync1;

      // Register writes
      if (i_wr) begin
         if (hit(i_addr, `PRS_ADDR_REF_CTRL)) begin
            r_d.ref_ctrl = i_wdata;
         end else if (hit(i_addr, `PRS_ADDR_HOLD_CTRL)) begin
            r_d.hold_ctrl = i_wdata;
         end
      end

      // Reference change sequencer
      want = pick_target(r_q.ref_ctrl, r_q.sel, r_q.sync2[S_SEL_PIN],
                         r_q.sync2[S_PRI_GOOD]);
      case (r_q.sw)
         prs_pkg::PRS_SW_RUN: begin
            r_d.ref_out = ref_level(r_q.sync2, r_q.sel);
            if (want != r_q.sel) begin
               if (r_q.ref_ctrl[`PRS_RC_NO_DEGLITCH]) begin
                  r_d.sel = want;
                  r_d.ref_out = ref_level(r_q.sync2, want);
               end else begin
                  r_d.tgt = want;
                  r_d.sw = prs_pkg::PRS_SW_DRAIN_OLD;
               end
            end
         end
         prs_pkg::PRS_SW_DRAIN_OLD: begin
            // Let the old high phase finish, then hold low
            r_d.ref_out = r_q.ref_out && ref_level(r_q.sync2, r_q.sel);
            if (!ref_level(r_q.sync2, r_q.sel)) begin
               r_d.ref_out = 1'b0;
               r_d.sw = prs_pkg::PRS_SW_WAIT_NEW;
            end
         end
         prs_pkg::PRS_SW_WAIT_NEW: begin
            // Join the new clock only while it is low
            r_d.ref_out = 1'b0;
            if (!ref_level(r_q.sync2, r_q.tgt)) begin
               r_d.sel = r_q.tgt;
               r_d.sw = prs_pkg::PRS_SW_RUN;
            end
         end
         default: begin
            r_d.sw = prs_pkg::PRS_SW_RUN;
         end
      endcase

      // Holdover control
      hold_en = r_q.hold_ctrl[`PRS_HC_HOLD_EN_B] && r_q.hold_ctrl[`PRS_HC_HOLD_EN_A];
      lock_ok = r_q.hold_ctrl[`PRS_HC_LOCK_CMP_EN] ? r_q.sync2[S_LOCK_PIN] : 1'b1;
      sel_good = r_q.sel ? r_q.sync2[S_SEC_GOOD] : r_q.sync2[S_PRI_GOOD];
      if (!hold_en) begin
         r_d.ho = prs_pkg::PRS_HO_TRACK;
         r_d.holdover = 1'b0;
      end else if (r_q.hold_ctrl[`PRS_HC_EXTERNAL]) begin
         r_d.ho = prs_pkg::PRS_HO_TRACK;
         r_d.holdover = !r_q.sync2[S_SYNC_N];
      end else begin
         case (r_q.ho)
            prs_pkg::PRS_HO_TRACK: begin
               if (!sel_good && lock_ok) begin
                  r_d.ho = prs_pkg::PRS_HO_HOLD;
               end
            end
            prs_pkg::PRS_HO_HOLD: begin
               if (sel_good) begin
                  r_d.ho = prs_pkg::PRS_HO_TRACK;
               end
            end
            default: begin
               r_d.ho = prs_pkg::PRS_HO_TRACK;
            end
         endcase
         r_d.holdover = (r_d.ho == prs_pkg::PRS_HO_HOLD);
      end

      // Status word
      status[`PRS_ST_CAL_DONE] = r_q.sync2[S_CAL_DONE];
      status[`PRS_ST_HOLDOVER] = r_q.holdover;
      status[`PRS_ST_SECONDARY] = r_q.sel;
      status[`PRS_ST_VCO_ABOVE] = r_q.sync2[S_VCO_ABOVE];
      status[`PRS_ST_SEC_ABOVE] = r_q.sync2[S_SEC_ABOVE];
      status[`PRS_ST_PRI_ABOVE] = r_q.sync2[S_PRI_ABOVE];
      status[`PRS_ST_DIG_LOCK] = r_q.sync2[S_DIG_LOCK];

      // Read data stands only in the cycle after the read strobe
      r_d.rdata = `PRS_UNMAPPED_RDATA;
      if (i_rd) begin
         if (hit(i_addr, `PRS_ADDR_REF_CTRL)) begin
            r_d.rdata = r_q.ref_ctrl;
         end else if (hit(i_addr, `PRS_ADDR_HOLD_CTRL)) begin
            r_d.rdata = r_q.hold_ctrl;
         end else if (hit(i_addr, `PRS_ADDR_PLL_STATUS)) begin
            if (!r_q.hold_ctrl[`PRS_HC_STATUS_OFF]) begin
               r_d.rdata = status;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         r_q.ref_ctrl <= `PRS_REF_CTRL_RST;
         r_q.hold_ctrl <= `PRS_HOLD_CTRL_RST;
         r_q.sync1 <= 12'h000;
         r_q.sync2 <= 12'h000;
         r_q.sel <= 1'b0;
         r_q.tgt <= 1'b0;
         r_q.ref_out <= 1'b0;
         r_q.holdover <= 1'b0;
         r_q.sw <= prs_pkg::PRS_SW_RUN;
         r_q.ho <= prs_pkg::PRS_HO_TRACK;
         r_q.rdata <= 8'h00;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Power: automatic mode keeps both inputs alive for monitoring
   assign o_pri_power = r_q.ref_ctrl[`PRS_RC_AUTO] || r_q.ref_ctrl[`PRS_RC_PRI_POWER];
   assign o_sec_power = r_q.ref_ctrl[`PRS_RC_AUTO] || r_q.ref_ctrl[`PRS_RC_SEC_POWER];
   assign o_differential = r_q.ref_ctrl[`PRS_RC_DIFFERENTIAL];
   assign o_ref_to_pll = r_q.ref_out;
   assign o_secondary_selected = r_q.sel;
   assign o_holdover = r_q.holdover;
   assign o_rdata = r_q.rdata;

endmodule
`default_nettype wire

// File: prs_ref_switch_ctrl_monitor.sv
// Port checker for the reference switch and holdover control block
`default_nettype none
module prs_ref_switch_ctrl_monitor #(
   parameter int ADDR_W = 10
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_ref_select_pin,
   input wire logic i_sync_n,
   input wire logic i_pri_status_good,
   input wire logic o_secondary_selected,
   input wire logic o_holdover,
   input wire logic o_pri_power,
   input wire logic o_sec_power,
   input wire logic o_differential
);
   logic [7:0] rc_q;
   logic [7:0] hc_q;
   logic man_reg;
   logic hold_on;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////
   // Shadow copies of both control registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rc_q <= 8'h00;
         hc_q <= 8'h00;
      end else if (i_wr) begin
         if (i_addr == 10'h01C) rc_q <= i_wdata;
         if (i_addr == 10'h01D) hc_q <= i_wdata;
      end
   end
   // Manual single-ended mode without deglitch, holdover enable pair
   assign man_reg = rc_q[7] && !rc_q[4] && !rc_q[0];
   assign hold_on = hc_q[2] && hc_q[0];
   ////////////////////////////////////////
   a_diff_bit: assert property (i_wr && i_addr == 10'h01C |=> o_differential == $past(i_wdata[0]))
      else $error("differential output does not follow control bit 0");
   a_power_bits: assert property (o_pri_power == (rc_q[4] || rc_q[1]) && o_sec_power == (rc_q[4] || rc_q[2]))
      else $error("reference power enables wrong");
   a_reg_select: assert property ((man_reg && !rc_q[5] && $stable(rc_q))[*4] |-> o_secondary_selected == rc_q[6])
      else $error("register select not obeyed");
   a_pin_select: assert property ((man_reg && rc_q[5] && $stable(rc_q) && $stable(i_ref_select_pin))[*5]
      |-> o_secondary_selected == i_ref_select_pin)
      else $error("select pin not obeyed");
   a_auto_leave: assert property ((rc_q[4] && rc_q[7] && !rc_q[0] && !i_pri_status_good)[*5]
      |-> o_secondary_selected)
      else $error("bad primary not left in automatic mode");
   a_auto_return: assert property ((rc_q[4] && rc_q[7] && !rc_q[3] && !rc_q[0] && i_pri_status_good)[*5]
      |-> !o_secondary_selected)
      else $error("good primary not taken back");
   a_hold_off: assert property (!hold_on [*2] |-> !o_holdover)
      else $error("holdover while not enabled");
   a_sync_hold: assert property ((hold_on && hc_q[1] && $stable(hc_q) && $stable(i_sync_n))[*5]
      |-> o_holdover == !i_sync_n)
      else $error("holdover does not follow sync pin");
   a_stat_off: assert property (i_rd && i_addr == 10'h01F && hc_q[4] |=> o_rdata == 8'h00)
      else $error("status readback not blanked");
   a_stat_bits: assert property (i_rd && i_addr == 10'h01F && !hc_q[4]
      |=> o_rdata[5] == $past(o_holdover) && o_rdata[4] == $past(o_secondary_selected))
      else $error("status holdover or selection bit wrong");
   // Main scenarios reached
   c_auto_sw: cover property (rc_q[4] && $rose(o_secondary_selected));
   c_hold: cover property ($rose(o_holdover));
   c_stat: cover property (i_rd && i_addr == 10'h01F);
endmodule
bind prs_ref_switch_ctrl prs_ref_switch_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

// File: prs_ref_switch_ctrl_tb.sv
// Self-checking bench for the reference switch and holdover control block
`default_nettype none
module prs_ref_switch_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic [9:0] i_addr = 10'h000;
   logic [7:0] i_wdata = 8'h00, o_rdata, rd_v;
   logic i_primary_reference, i_secondary_reference, i_ref_select_pin = 1'h0;
   logic i_lock_indicator_pin = 1'h0, i_sync_n = 1'h1, i_pri_status_good = 1'h1;
   logic i_sec_status_good = 1'h1, i_pri_above_thr = 1'h0, i_sec_above_thr = 1'h0;
   logic i_vco_above_thr = 1'h0, i_vco_cal_done = 1'h0, i_dig_lock = 1'h0;
   logic o_ref_to_pll, o_secondary_selected, o_holdover, o_pri_power, o_sec_power;
   logic o_differential;
   int error_cnt = 0, n_tests = 0;
   prs_ref_switch_ctrl #(.ADDR_W(10)) DUT (.*);
   prs_ref_src #(.HALF_NS(350)) u_pri (.i_en(o_pri_power), .o_clk(i_primary_reference));
   prs_ref_src #(.HALF_NS(450)) u_sec (.i_en(o_sec_power), .o_clk(i_secondary_reference));
   // Clock
   initial forever #50 i_mclk = !i_mclk;
   ////////////////////////////////////////
   task automatic stop_test();
      $display("Tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Register port cycles
   task automatic wr(logic [9:0] a, logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(logic [9:0] a);
      @(posedge i_mclk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      #1;
      rd_v = o_rdata;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic wait_for(string nm, ref logic s, input logic v);
      int k;
      for (k = 0; k < 300 && s !== v; k++) @(posedge i_mclk);
      chk(nm, {7'h00, s}, {7'h00, v});
      if (s !== v) stop_test();
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(10'h01C);
      chk("ref ctrl", rd_v, 8'h00);
      rd(10'h01D);
      chk("hold ctrl", rd_v, 8'h00);
      wr(10'h01F, 8'hFF);
      rd(10'h3A0);
      chk("unmapped", rd_v, 8'h00);
      chk("pins", {5'h00, o_differential, o_sec_power, o_pri_power}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_manual();
      wr(10'h01C, 8'hC6);
      wait_for("reg sel", o_secondary_selected, 1'h1);
      rd(10'h01F);
      chk("st sel", {7'h00, rd_v[4]}, 8'h01);
      chk("pwr", {6'h00, o_sec_power, o_pri_power}, 8'h03);
      wr(10'h01C, 8'hA2);
      chk("pwr", {6'h00, o_sec_power, o_pri_power}, 8'h01);
      wait_for("pin low", o_secondary_selected, 1'h0);
      @(posedge i_mclk);
      i_ref_select_pin <= 1'h1;
      wait_for("pin sel", o_secondary_selected, 1'h1);
      @(posedge i_mclk);
      i_ref_select_pin <= 1'h0;
      wait_for("pin sel", o_secondary_selected, 1'h0);
      wr(10'h01C, 8'h46);
      wait_for("deglitch sel", o_secondary_selected, 1'h1);
      wait_for("pll ref", o_ref_to_pll, 1'h1);
      wr(10'h01C, 8'h47);
      wait_for("diff sel", o_secondary_selected, 1'h0);
      $display("manual test done");
   endtask
   task automatic t_auto();
      wr(10'h01C, 8'h90); // Single-ended while automatic
      @(posedge i_mclk);
      i_pri_status_good <= 1'h0;
      wait_for("auto sel", o_secondary_selected, 1'h1);
      @(posedge i_mclk);
      i_pri_status_good <= 1'h1;
      wait_for("auto back", o_secondary_selected, 1'h0);
      wr(10'h01C, 8'h98);
      @(posedge i_mclk);
      i_pri_status_good <= 1'h0;
      wait_for("auto sel", o_secondary_selected, 1'h1);
      @(posedge i_mclk);
      i_pri_status_good <= 1'h1;
      idle(10);
      chk("stay sec", {7'h00, o_secondary_selected}, 8'h01);
      wr(10'h01C, 8'h82);
      wait_for("man pri", o_secondary_selected, 1'h0);
      $display("auto test done");
   endtask
   task automatic t_hold();
      wr(10'h01D, 8'h01); // No calibration runs here
      @(posedge i_mclk);
      i_pri_status_good <= 1'h0;
      idle(10);
      chk("half enable", {7'h00, o_holdover}, 8'h00);
      wr(10'h01D, 8'h05);
      wait_for("auto hold", o_holdover, 1'h1);
      rd(10'h01F);
      chk("st hold", {7'h00, rd_v[5]}, 8'h01);
      i_pri_status_good <= 1'h1;
      wait_for("hold exit", o_holdover, 1'h0);
      wr(10'h01D, 8'h0D);
      i_pri_status_good <= 1'h0;
      idle(10);
      chk("no lock", {7'h00, o_holdover}, 8'h00);
      i_pri_status_good <= 1'h1;
      i_lock_indicator_pin <= 1'h1;
      idle(5);
      i_pri_status_good <= 1'h0;
      wait_for("lock hold", o_holdover, 1'h1);
      i_pri_status_good <= 1'h1;
      wr(10'h01D, 8'h07);
      wait_for("sync idle", o_holdover, 1'h0);
      i_sync_n <= 1'h0;
      wait_for("sync hold", o_holdover, 1'h1);
      @(posedge i_mclk);
      i_sync_n <= 1'h1;
      wait_for("sync free", o_holdover, 1'h0);
      wr(10'h01D, 8'h15);
      rd(10'h01F);
      chk("st off", rd_v, 8'h00);
      $display("holdover test done");
   endtask
   task automatic t_status();
      int i;
      wr(10'h01D, 8'h00);
      for (i = 0; i < 5; i++) begin
         {i_vco_cal_done, i_vco_above_thr, i_sec_above_thr, i_pri_above_thr, i_dig_lock} <=
            5'h01 << i;
         idle(4);
         rd(10'h01F);
         chk("status", rd_v & 8'hCF, (i == 4) ? 8'h40 : (8'h01 << i));
      end
      $display("status test done");
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'h0;
      t_reset();
      t_manual();
      t_auto();
      t_hold();
      t_status();
      stop_test();
   end
endmodule
`default_nettype wire
